// >>> verilog/isar_top.sv
// Purpose: two-wire bus target, address match, acknowledge and byte receive
// Assumes: bus lines are asynchronous and pass two flops before use
// Notes: slave transmit is not handled; a read request raises port_irq_flag and stretches SCL, nothing is sent
`timescale 1ns/1ps
module isar_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] port_mode_field_i,
  input wire logic [7:0] own_address_i,
  input wire logic own_address_wr_i,
  input wire logic [7:0] address_mask_i,
  input wire logic ack_value_select_i,
  input wire logic address_hold_enable_i,
  input wire logic data_hold_enable_i,
  input wire logic stretch_enable_i,
  input wire logic buffer_overwrite_enable_i,
  input wire logic start_irq_enable_i,
  input wire logic stop_irq_enable_i,
  input wire logic clock_release_set_i,
  input wire logic irq_clear_i,
  input wire logic overflow_clear_i,
  input wire logic buffer_read_i,
  output logic [7:0] shift_buffer_o,
  output logic buffer_full_o,
  output logic port_irq_flag_o,
  output logic received_ack_result_o,
  output logic ack_phase_flag_o,
  output logic update_address_pending_o,
  output logic receive_overflow_o,
  output logic start_seen_o,
  output logic stop_seen_o,
  output logic read_write_o,
  output logic clock_release_o
);

  typedef struct packed {
    isar_pkg::isar_state_t st;
    isar_pkg::isar_state_t after_ack;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic ack_slot;
    logic ack_ok;
    logic hold;
    logic sda_oe;
    logic scl_oe;
    logic rel;
    logic ua;
    logic prior;
    logic irq;
    logic ov;
    logic received_ack_result;
    logic ackt;
    logic start_seen;
    logic stop_seen;
    logic rw;
    logic push;
  } isar_core_t;

  isar_core_t s_r;
  isar_core_t s_nxt;

  logic fifo_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;

  isar_fifo2 #(
    .WIDTH(isar_pkg::BYTE_W),
    .DEPTH(isar_pkg::BUF_DEPTH)
  ) u_rxbuf (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .in_valid_i(s_r.push),
    .in_data_i(s_r.shreg),
    .in_ready_o(fifo_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(buffer_read_i)
  );

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic ten_bit;
    logic ss_irq;
    logic room;
    logic match;
    logic hi_match;
    logic take;
    logic active;
    logic [7:0] hi_pat;
    logic [7:0] hi_msk;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_det = 1'b0;
    stop_det = 1'b0;
    ten_bit = 1'b0;
    ss_irq = 1'b0;
    room = 1'b0;
    match = 1'b0;
    hi_match = 1'b0;
    take = 1'b0;
    active = 1'b0;
    hi_pat = '0;
    hi_msk = '0;
    s_nxt = s_r;

    // first flop feeds only the second
    s_nxt.scl_m = scl_i;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_d = s_r.scl_s;
    s_nxt.sda_m = sda_i;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_d = s_r.sda_s;

    scl_rise = s_r.scl_s & ~s_r.scl_d;
    scl_fall = ~s_r.scl_s & s_r.scl_d;
    start_det = s_r.scl_s & s_r.scl_d & s_r.sda_d & ~s_r.sda_s;
    stop_det = s_r.scl_s & s_r.scl_d & ~s_r.sda_d & s_r.sda_s;

    ten_bit = port_mode_field_i[isar_pkg::MODE_TEN_BIT];
    ss_irq = port_mode_field_i[isar_pkg::MODE_SS_IRQ];
    // overwrite enable lets a byte in while the head is unread
    room = ~s_r.ov & (~fifo_valid | buffer_overwrite_enable_i);
    hi_pat = {isar_pkg::TEN_HI_PREFIX, own_address_i[2:1], 1'b0};
    hi_msk = {isar_pkg::TEN_HI_PREFIX_MASK, address_mask_i[2:1], 1'b0};
    active = s_r.st == isar_pkg::ST_ADDR || s_r.st == isar_pkg::ST_ADDR_LO ||
             s_r.st == isar_pkg::ST_DATA;

    // software side; hardware events below override these
    if (irq_clear_i) begin
      s_nxt.irq = 1'b0;
    end
    if (overflow_clear_i) begin
      s_nxt.ov = 1'b0;
    end
    if (clock_release_set_i) begin
      s_nxt.rel = 1'b1;
    end
    if (own_address_wr_i) begin
      s_nxt.ua = 1'b0;
    end
    if (s_r.push && fifo_ready) begin
      s_nxt.push = 1'b0;
    end

    if (start_det) begin
      // restart is handled like a start; state, bit count and ack slot reset, the 10-bit prior write match is kept
      s_nxt.st = isar_pkg::ST_ADDR;
      s_nxt.bits = '0;
      s_nxt.ack_slot = 1'b0;
      s_nxt.ackt = 1'b0;
      s_nxt.start_seen = 1'b1;
      s_nxt.stop_seen = 1'b0;
      if (ss_irq || start_irq_enable_i) begin
        s_nxt.irq = 1'b1;
      end
    end else if (stop_det) begin
      s_nxt.st = isar_pkg::ST_IDLE;
      s_nxt.bits = '0;
      s_nxt.ack_slot = 1'b0;
      s_nxt.ackt = 1'b0;
      s_nxt.prior = 1'b0;
      s_nxt.stop_seen = 1'b1;
      s_nxt.start_seen = 1'b0;
      if (ss_irq || stop_irq_enable_i) begin
        s_nxt.irq = 1'b1;
      end
    end else if (active) begin
      if (scl_rise) begin
        if (!s_r.ack_slot) begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s};
          s_nxt.bits = s_r.bits + 4'h1;
        end else begin
          s_nxt.received_ack_result = s_r.sda_s;
        end
      end
      if (scl_fall && !s_r.ack_slot && s_r.bits == isar_pkg::BYTE_BITS) begin
        // eighth falling edge: decide the acknowledge
        s_nxt.bits = '0;
        s_nxt.ack_slot = 1'b1;
        s_nxt.hold = data_hold_enable_i;
        s_nxt.after_ack = isar_pkg::ST_DATA;
        if (s_r.st == isar_pkg::ST_ADDR) begin
          s_nxt.hold = address_hold_enable_i;
          s_nxt.rw = s_r.shreg[0];
          if (ten_bit) begin
            hi_match = ((s_r.shreg ^ hi_pat) & hi_msk) == 8'h00;
            // read needs a completed write match first
            match = hi_match & (~s_r.shreg[0] | s_r.prior);
            if (!hi_match || !s_r.shreg[0]) begin
              s_nxt.prior = 1'b0;
            end
            s_nxt.after_ack = s_r.shreg[0] ? isar_pkg::ST_READ : isar_pkg::ST_ADDR_LO;
            take = match & s_r.shreg[0] & room;
          end else begin
            match = ((s_r.shreg ^ own_address_i) & address_mask_i &
                     isar_pkg::DIR_BIT_EXCLUDE) == 8'h00;
            s_nxt.after_ack = s_r.shreg[0] ? isar_pkg::ST_READ : isar_pkg::ST_DATA;
            take = match & room;
          end
        end else if (s_r.st == isar_pkg::ST_ADDR_LO) begin
          s_nxt.hold = address_hold_enable_i;
          match = ((s_r.shreg ^ own_address_i) & address_mask_i) == 8'h00;
          take = match & room;
        end else begin
          match = 1'b1;
          take = room;
        end
        if (!match && s_r.st == isar_pkg::ST_ADDR) begin
          s_nxt.st = isar_pkg::ST_IGNORE;
          s_nxt.ack_slot = 1'b0;
        end else begin
          s_nxt.ack_ok = match & room;
          s_nxt.push = take;
          if (match && !room && fifo_valid) begin
            s_nxt.ov = 1'b1;
          end
          if (s_nxt.hold) begin
            s_nxt.rel = 1'b0;
            s_nxt.irq = 1'b1;
            s_nxt.ackt = 1'b1;
          end
        end
      end else if (scl_fall && s_r.ack_slot) begin
        // ninth falling edge: act on what was sent
        s_nxt.ack_slot = 1'b0;
        s_nxt.ackt = 1'b0;
        if (s_r.st == isar_pkg::ST_ADDR_LO) begin
          // flags rise whether or not the low byte matched
          s_nxt.irq = 1'b1;
          s_nxt.ua = 1'b1;
          s_nxt.prior = s_r.sda_oe;
        end
        if (!s_r.sda_oe) begin
          s_nxt.st = isar_pkg::ST_IGNORE;
        end else begin
          s_nxt.st = s_r.after_ack;
          unique case (s_r.st)
            isar_pkg::ST_ADDR: begin
              if (s_r.after_ack == isar_pkg::ST_ADDR_LO) begin
                s_nxt.ua = 1'b1;
              end else if (s_r.after_ack == isar_pkg::ST_READ) begin
                // transmit data must be prepared before release
                s_nxt.irq = 1'b1;
                s_nxt.rel = 1'b0;
              end else begin
                s_nxt.irq = 1'b1;
                if (stretch_enable_i) begin
                  s_nxt.rel = 1'b0;
                end
              end
            end
            isar_pkg::ST_ADDR_LO: begin
              s_nxt.st = isar_pkg::ST_DATA;
            end
            isar_pkg::ST_DATA: begin
              s_nxt.irq = 1'b1;
              if (stretch_enable_i) begin
                s_nxt.rel = 1'b0;
              end
            end
            default: begin
              s_nxt.st = isar_pkg::ST_IGNORE;
            end
          endcase
        end
      end
    end

    // acknowledge is driven only in the slot, level per hold mode
    s_nxt.sda_oe = s_nxt.ack_slot & s_nxt.ack_ok &
                   (~s_nxt.hold | ~ack_value_select_i);
    // stretch for software, address update, or a full buffer
    s_nxt.scl_oe = ~s_nxt.rel | s_nxt.ua | (s_nxt.push & ~fifo_ready);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.rel <= isar_pkg::CLK_RELEASE_RST;
      s_r.scl_m <= isar_pkg::LINE_IDLE_RST;
      s_r.scl_s <= isar_pkg::LINE_IDLE_RST;
      s_r.scl_d <= isar_pkg::LINE_IDLE_RST;
      s_r.sda_m <= isar_pkg::LINE_IDLE_RST;
      s_r.sda_s <= isar_pkg::LINE_IDLE_RST;
      s_r.sda_d <= isar_pkg::LINE_IDLE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open-drain: only ever pull low
  assign scl_o = isar_pkg::PIN_DRIVE_LEVEL;
  assign sda_o = isar_pkg::PIN_DRIVE_LEVEL;
  assign scl_oe_o = s_r.scl_oe;
  assign sda_oe_o = s_r.sda_oe;
  assign shift_buffer_o = fifo_data;
  assign buffer_full_o = fifo_valid;
  assign port_irq_flag_o = s_r.irq;
  assign received_ack_result_o = s_r.received_ack_result;
  assign ack_phase_flag_o = s_r.ackt;
  assign update_address_pending_o = s_r.ua;
  assign receive_overflow_o = s_r.ov;
  assign start_seen_o = s_r.start_seen;
  assign stop_seen_o = s_r.stop_seen;
  assign read_write_o = s_r.rw;
  assign clock_release_o = s_r.rel;
endmodule

// >>> verilog/isar_pkg.sv
// Purpose: constants and types for the two-wire target receive block
// Assumes: 10 MHz core clock, bus clock sampled as an ordinary input
// Notes: control and status bits are plain ports, no register bus
// Overview of operation
// - start/stop enable bits add port_irq_flag in modes lacking start/stop interrupts
// - ninth SCL pulse is acknowledge slot; receiver pulls SDA low to acknowledge
// - SDA level sampled in acknowledge slot is kept as received_ack_result
// - with address/data hold, acknowledge level comes from ack_value_select
// - with both hold enables clear, hardware acknowledges on its own
// - no acknowledge when receive_overflow, or buffer_full without overwrite enable, already set at arrival
// - ack_phase_flag set after eighth falling SCL edge, only with a hold enabled
// - port_mode_field picks one of four modes, 7-bit or 10-bit addressing
// - start/stop interrupt modes also raise port_irq_flag on Start, Restart, Stop
// - first byte after Start compared to own address; mismatch idles silently
// - address_mask_reg qualifies the address comparison
// - 7-bit addressing ignores the direction bit when matching
// - 10-bit high byte matched against 11110, A9, A8, 0 from own address bits 2:1
// - after acknowledged high byte set update_address_pending and hold SCL low
// - after low byte set flags, stretch until own address rewritten, write clears
// - 10-bit read only after full write match then Restart with direction set
// - matching write address clears direction status, is acknowledged, and is buffered except a 10-bit high byte
// - overflow on received address gives not-acknowledge, modified by overwrite enable
// - port_irq_flag set for every acknowledged data byte, stays until software clears it
// - with stretch_enable SCL held low after each byte until clock_release set
// - reading the received byte clears buffer_full unless a second byte is buffered
// - Start sets start-seen, Stop sets stop-seen and returns to idle
// - Start is SDA falling while SCL stays high
// - Stop is SDA rising while SCL stays high
// - data bits sampled on SCL rising edge, SDA changes only while SCL low
// - bytes shift most significant bit first
package isar_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_IGNORE = 3'b101
  } isar_state_t;

  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // port_mode_field bit positions
  localparam int MODE_TEN_BIT = 0;
  localparam int MODE_SS_IRQ = 1;
  // 10-bit high byte prefix and its comparison mask
  localparam logic [4:0] TEN_HI_PREFIX = 5'h1E;
  localparam logic [4:0] TEN_HI_PREFIX_MASK = 5'h1F;
  localparam logic [7:0] DIR_BIT_EXCLUDE = 8'hFE;
  // reset values and pin drive level
  localparam logic CLK_RELEASE_RST = 1'b1;
  localparam logic LINE_IDLE_RST = 1'b1;
  localparam logic PIN_DRIVE_LEVEL = 1'b0;

endpackage

// >>> verilog/isar_fifo2.sv
// Purpose: small receive buffer between byte engine and software reader
// Assumes: single clock, push and pop may coincide
// Notes: head entry and flags are flops, so outputs need no mux
`timescale 1ns/1ps
module isar_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [CW-1:0] cnt;
    logic vld;
    logic rdy;
  } isar_fifo_t;

  isar_fifo_t s_r;
  isar_fifo_t s_nxt;

  always_comb begin
    logic push;
    logic pop;
    logic [CW-1:0] wr;
    push = 1'b0;
    pop = 1'b0;
    wr = '0;
    s_nxt = s_r;
    pop = s_r.vld & out_ready_i;
    push = in_valid_i & s_r.rdy;
    wr = s_r.cnt - CW'(pop);
    // entries shift toward the head on a pop
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        s_nxt.ent[i] = s_r.ent[i + 1];
      end
      if (push && wr == CW'(i)) begin
        s_nxt.ent[i] = in_data_i;
      end
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
    s_nxt.vld = s_nxt.cnt != '0;
    s_nxt.rdy = s_nxt.cnt != FULL_CNT;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_o = s_r.rdy;
  assign out_valid_o = s_r.vld;
  assign out_data_o = s_r.ent[0];
endmodule

// >>> sim/isar_chk.sv
// Purpose: port-level protocol checks for the two-wire target
// Assumes: one clock domain, bus lines seen as resolved levels
// Notes: bound to every isar_top instance
`timescale 1ns/1ps
module isar_chk (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic own_address_wr_i,
  input wire logic ack_value_select_i,
  input wire logic address_hold_enable_i,
  input wire logic data_hold_enable_i,
  input wire logic buffer_overwrite_enable_i,
  input wire logic clock_release_set_i,
  input wire logic irq_clear_i,
  input wire logic buffer_full_o,
  input wire logic port_irq_flag_o,
  input wire logic ack_phase_flag_o,
  input wire logic update_address_pending_o,
  input wire logic receive_overflow_o,
  input wire logic start_seen_o,
  input wire logic stop_seen_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_start_cond;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence s_stop_cond;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  a_start_seen_set: assert property (s_start_cond |-> ##[1:6] start_seen_o)
    else $error("start not flagged");
  a_stop_seen_set: assert property (s_stop_cond |-> ##[1:6] stop_seen_o)
    else $error("stop not flagged");
  a_sda_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  a_phase_needs_hold: assert property ($rose(ack_phase_flag_o) |-> address_hold_enable_i || data_hold_enable_i)
    else $error("ack phase flag without hold");
  a_hold_ack_value: assert property ($rose(ack_phase_flag_o) |-> ##[0:1] (scl_oe_o && sda_oe_o == !ack_value_select_i))
    else $error("held ack level or stretch wrong");
  a_irq_held_set: assert property (port_irq_flag_o && !irq_clear_i |=> port_irq_flag_o)
    else $error("irq flag dropped without clear");
  a_ua_write_clears: assert property (own_address_wr_i && update_address_pending_o |=> !update_address_pending_o)
    else $error("address write left update pending");
  a_ua_holds_clock: assert property ($rose(update_address_pending_o) |-> ##[0:1] scl_oe_o)
    else $error("update pending without stretch");
  a_release_frees_clock: assert property (clock_release_set_i && ack_phase_flag_o |-> ##[1:2] !scl_oe_o)
    else $error("clock not released");
  a_no_ack_full: assert property ($rose(sda_oe_o) && !buffer_overwrite_enable_i |->
    !$past(buffer_full_o) && !$past(receive_overflow_o))
    else $error("ack given while buffer full");
endmodule
bind isar_top isar_chk chk_i(.*);

// >>> sim/isar_bus_master.sv
// Purpose: bus controller model driving clock and data open-drain
// Assumes: 800 ns bus clock, 500 ns low and 300 ns high
// Notes: waits while the target stretches the clock
`timescale 1ns/1ps
module isar_bus_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  // bounded so a stuck stretch cannot hang the run
  task automatic wait_hi();
    int n;
    n = 0;
    scl_oe_o = 1'b0;
    while (!scl_i && n < 3000) begin
      #100 n++;
    end
  endtask
  task automatic put_bit(input logic b, output logic r);
    #100 sda_oe_o = ~b;
    #400 wait_hi();
    #150 r = sda_i;
    #150 scl_oe_o = 1'b1;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, ack);
  endtask
  task automatic start();
    #100 sda_oe_o = 1'b0;
    #400 wait_hi();
    #400 sda_oe_o = 1'b1;
    #400 scl_oe_o = 1'b1;
  endtask
  task automatic stop();
    #100 sda_oe_o = 1'b1;
    #400 wait_hi();
    #400 sda_oe_o = 1'b0;
    #800;
  endtask
endmodule

// >>> sim/isar_tb_top.sv
// Purpose: self-checking bench for the two-wire target receive block
// Assumes: 10 MHz core clock, controller model on the far side
// Notes: slave transmit is not exercised, only the read request
`timescale 1ns/1ps
module isar_tb_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl_i, sda_i, scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe, a;
  logic [1:0] port_mode_field_i = 2'h0;
  logic [7:0] own_address_i = 8'h55;
  logic [7:0] address_mask_i = 8'hFF;
  logic [7:0] shift_buffer_o;
  logic own_address_wr_i = 1'b0, ack_value_select_i = 1'b0, address_hold_enable_i = 1'b0;
  logic data_hold_enable_i = 1'b0, stretch_enable_i = 1'b0, buffer_overwrite_enable_i = 1'b0;
  logic start_irq_enable_i = 1'b0, stop_irq_enable_i = 1'b0, clock_release_set_i = 1'b0;
  logic irq_clear_i = 1'b0, overflow_clear_i = 1'b0, buffer_read_i = 1'b0;
  logic buffer_full_o, port_irq_flag_o, received_ack_result_o, ack_phase_flag_o;
  logic update_address_pending_o, receive_overflow_o, start_seen_o, stop_seen_o;
  logic read_write_o, clock_release_o;
  int num_errors = 0;
  int checks_done = 0;
  // open-drain lines with pull-ups
  assign scl_i = ~(m_scl_oe | scl_oe_o);
  assign sda_i = ~(m_sda_oe | sda_oe_o);
  always #50 mclk_i = ~mclk_i;
  isar_top dut(.*);
  isar_bus_master m(.scl_i(scl_i), .sda_i(sda_i), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask
  task automatic tidy();
    cyc(8);
    pulse(irq_clear_i);
    pulse(overflow_clear_i);
    pulse(buffer_read_i);
    pulse(buffer_read_i);
  endtask
  task automatic t_write7();
    start_irq_enable_i = 1'b1;
    stop_irq_enable_i = 1'b1;
    m.start();
    cyc(6);
    chk(8'({start_seen_o, port_irq_flag_o}), 8'h03);
    pulse(irq_clear_i);
    m.send(8'h54, a);
    cyc(6);
    chk(8'({a, received_ack_result_o, read_write_o, port_irq_flag_o, buffer_full_o}), 8'h03);
    chk(shift_buffer_o, 8'h54);
    pulse(buffer_read_i);
    chk(8'(buffer_full_o), 8'h00);
    pulse(irq_clear_i);
    m.send(8'hA5, a);
    cyc(6);
    chk(8'({a, port_irq_flag_o}), 8'h01);
    chk(shift_buffer_o, 8'hA5);
    m.send(8'h3C, a);
    cyc(6);
    chk(8'({a, received_ack_result_o, receive_overflow_o}), 8'h07);
    pulse(overflow_clear_i);
    chk(8'(receive_overflow_o), 8'h00);
    pulse(irq_clear_i);
    m.stop();
    cyc(6);
    chk(8'({stop_seen_o, port_irq_flag_o}), 8'h03);
    start_irq_enable_i = 1'b0;
    stop_irq_enable_i = 1'b0;
    tidy();
  endtask
  task automatic t_mask();
    port_mode_field_i = 2'h2;
    m.start();
    cyc(6);
    chk(8'(port_irq_flag_o), 8'h01);
    pulse(irq_clear_i);
    m.send(8'h20, a);
    cyc(6);
    chk(8'({a, port_irq_flag_o, buffer_full_o}), 8'h04);
    m.stop();
    cyc(6);
    chk(8'(port_irq_flag_o), 8'h01);
    tidy();
    address_mask_i = 8'hF0;
    m.start();
    m.send(8'h5E, a);
    cyc(6);
    chk(8'(a), 8'h00);
    chk(shift_buffer_o, 8'h5E);
    // head left unread: overwrite enable must still let the byte in
    buffer_overwrite_enable_i = 1'b1;
    m.send(8'h11, a);
    cyc(6);
    chk(8'({a, buffer_full_o, receive_overflow_o}), 8'h02);
    chk(shift_buffer_o, 8'h5E);
    pulse(buffer_read_i);
    chk(shift_buffer_o, 8'h11);
    buffer_overwrite_enable_i = 1'b0;
    m.stop();
    tidy();
    address_mask_i = 8'hFF;
    port_mode_field_i = 2'h0;
  endtask
  task automatic t_hold(input logic v);
    int n;
    address_hold_enable_i = 1'b1;
    data_hold_enable_i = 1'b1;
    stretch_enable_i = ~v;
    ack_value_select_i = v;
    m.start();
    fork
      m.send(8'h54, a);
      begin
        for (n = 0; n < 200 && !ack_phase_flag_o; n++) cyc(1);
        chk(8'({ack_phase_flag_o, scl_oe_o, clock_release_o}), 8'h06);
        pulse(clock_release_set_i);
      end
    join
    chk(8'(a), 8'(v));
    cyc(8);
    if (!v) begin
      chk(8'(scl_oe_o), 8'h01);
      pulse(clock_release_set_i);
    end
    m.stop();
    tidy();
    address_hold_enable_i = 1'b0;
    data_hold_enable_i = 1'b0;
    stretch_enable_i = 1'b0;
  endtask
  task automatic t_ten();
    int n;
    port_mode_field_i = 2'h1;
    own_address_i = 8'h06;
    m.start();
    fork
      begin
        m.send(8'hF6, a);
        chk(8'(a), 8'h00);
        m.send(8'h9A, a);
        chk(8'(a), 8'h00);
      end
      for (int i = 0; i < 2; i++) begin
        for (n = 0; n < 300 && !update_address_pending_o; n++) cyc(1);
        chk(8'({update_address_pending_o, scl_oe_o}), 8'h03);
        own_address_i = (i == 0) ? 8'h9A : 8'h06;
        pulse(own_address_wr_i);
        cyc(1);
        chk(8'(update_address_pending_o), 8'h00);
      end
    join
    chk(shift_buffer_o, 8'h9A);
    pulse(buffer_read_i);
    m.start();
    m.send(8'hF7, a);
    cyc(6);
    chk(8'({a, read_write_o}), 8'h01);
    pulse(clock_release_set_i);
    m.stop();
    cyc(6);
    chk(8'(stop_seen_o), 8'h01);
    tidy();
    port_mode_field_i = 2'h0;
    own_address_i = 8'h55;
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    chk(8'({clock_release_o, port_irq_flag_o, buffer_full_o, scl_oe_o, sda_oe_o, update_address_pending_o,
      start_seen_o, stop_seen_o}), 8'h80);
    chk(8'({scl_o, sda_o}), 8'h00);
    cyc(2);
    resetn_i = 1'b1;
    cyc(4);
    t_write7();
    t_mask();
    t_hold(1'b0);
    t_hold(1'b1);
    t_ten();
    conclude();
  end
  // a run of this length is far beyond what the scenarios need
  initial begin
    #3000000;
    num_errors++;
    conclude();
  end
endmodule
